// File: lit_trap_ctrl.sv
`timescale 1ns/1ps
module lit_trap_ctrl import lit_pkg::*; (
    input  wire logic                 CLK,
    input  wire logic                 RESET_N,
    input  wire lit_reg_req_t         REG_REQ,
    output logic [31:0]               REG_RDATA,
    input  wire lit_core_req_t        CORE_REQ,
    output lit_trap_t                 TRAP_OUT,
    input  wire logic [NUM_LOCAL-1:0] IRQ_LOCAL,
    input  wire logic                 IRQ_SW,
    input  wire logic                 IRQ_TIMER,
    input  wire logic                 IRQ_EXT
);
    lit_state_t        st;       // Registered state
    lit_state_t        next_st;  // Next state
    logic [NUM_ID-1:0] raw_irq;  // Pin levels by id
    logic              clic;     // Controller vector modes
    logic              arb_valid;
    logic [7:0]        arb_id;
    logic [7:0]        arb_cfg;
    logic [7:0]        arb_lvl;  // Level of the winner
    logic              take_irq; // Interrupt entry this cycle
    logic              take_exc; // Exception entry this cycle
    logic              mret_go;  // Return this cycle
    logic [8:0]        wsel;     // Write window decode
    logic [8:0]        rsel;     // Read window decode

    // Map pins onto the id space; unused ids stay low
    always_comb begin
        raw_irq = '0;
        raw_irq[ID_SW] = IRQ_SW;
        raw_irq[ID_TIMER] = IRQ_TIMER;
        raw_irq[ID_EXT] = IRQ_EXT;
        raw_irq[ID_LOCAL0 +: NUM_LOCAL] = IRQ_LOCAL;
    end

    assign clic = st.tvec[1];

    // Winner among synchronised pending lines
    lit_arbiter u_arb (
        .pend    (st.sync2),
        .en      (st.ien),
        .cfg     (st.icfg),
        .clic    (clic),
        .valid   (arb_valid),
        .id      (arb_id),
        .win_cfg (arb_cfg)
    );

    // Level of the winner from its config and the level-bit count
    assign arb_lvl = lit_level(arb_cfg, st.nlbits);

    // Exceptions outrank returns, returns outrank interrupts
    assign take_exc = CORE_REQ.exc;
    assign mret_go  = CORE_REQ.mret && !CORE_REQ.exc;
    // Plain modes ignore levels; controller modes need a strictly higher one
    assign take_irq = st.mie && arb_valid && !CORE_REQ.exc && !CORE_REQ.mret
                      && (!clic || arb_lvl > st.lvl);

    assign wsel = lit_irq_sel(REG_REQ.addr);
    assign rsel = wsel;

    assign REG_RDATA = st.rdata;
    assign TRAP_OUT  = st.trap;

    // Next-state logic: software writes first, trap hardware overrides
    always_comb begin
        logic [31:0] base;
        next_st = st;
        next_st.sync1 = raw_irq;
        next_st.sync2 = st.sync1;
        next_st.trap.pc_load = 1'b0;
        next_st.trap.irq = 1'b0;
        next_st.trap.vec_table = 1'b0;
        next_st.rdata = 32'h0000_0000;
        base = 32'h0000_0000;

        // Read data held for exactly the cycle after the strobe
        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                OFF_STATUS: begin
                    next_st.rdata[ST_MIE] = st.mie;
                    next_st.rdata[ST_PEN] = st.prior_irq_enable;
                    next_st.rdata[ST_PPM +: 2] = st.prior_priv_mode;
                end
                OFF_CAUSE: begin
                    next_st.rdata[CA_INT] = st.cause_int;
                    next_st.rdata[CA_PPM +: 2] = st.prior_priv_mode;
                    next_st.rdata[CA_PEN] = st.prior_irq_enable;
                    next_st.rdata[CA_PLV +: 8] = st.prior_irq_level;
                    next_st.rdata[11:0] = st.code;
                end
                OFF_TVEC:      next_st.rdata = st.tvec;
                OFF_EPC:       next_st.rdata = st.epc;
                OFF_TVT:       next_st.rdata = st.tvt;
                // Only the level is shown; privilege stays hidden
                OFF_INTSTATUS: next_st.rdata[IS_LVL +: 8] = st.lvl;
                OFF_CFG:       next_st.rdata[4:1] = st.nlbits;
                default: begin
                    // Per-interrupt word; unmapped reads give zero
                    if (rsel[8]) begin
                        next_st.rdata[7:0] = st.icfg[rsel[7:0]];
                        next_st.rdata[IC_EN] = st.ien[rsel[7:0]];
                        next_st.rdata[IC_PEND] = st.sync2[rsel[7:0]];
                    end
                end
            endcase
        end

        // Software writes
        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                OFF_STATUS: begin
                    // Only an explicit write or a return sets the enable again
                    next_st.mie = REG_REQ.wdata[ST_MIE];
                    next_st.prior_irq_enable = REG_REQ.wdata[ST_PEN];
                    next_st.prior_priv_mode = REG_REQ.wdata[ST_PPM +: 2];
                end
                OFF_CAUSE: begin
                    next_st.cause_int = REG_REQ.wdata[CA_INT];
                    next_st.prior_priv_mode = REG_REQ.wdata[CA_PPM +: 2];
                    next_st.prior_irq_enable = REG_REQ.wdata[CA_PEN];
                    next_st.prior_irq_level = REG_REQ.wdata[CA_PLV +: 8];
                    next_st.code = REG_REQ.wdata[11:0];
                end
                OFF_TVEC:      next_st.tvec = REG_REQ.wdata;
                OFF_EPC:       next_st.epc = {REG_REQ.wdata[31:1], 1'b0};
                OFF_TVT:       next_st.tvt = {REG_REQ.wdata[31:6], 6'h00};
                OFF_CFG: begin
                    // Clamped so at most sixteen levels exist
                    if (REG_REQ.wdata[4:1] > MAX_NLBITS) begin
                        next_st.nlbits = MAX_NLBITS;
                    end else begin
                        next_st.nlbits = REG_REQ.wdata[4:1];
                    end
                end
                default: begin
                    // Level status is read-only; other holes ignore writes
                    if (wsel[8]) begin
                        next_st.icfg[wsel[7:0]] = REG_REQ.wdata[7:0];
                        next_st.ien[wsel[7:0]] = REG_REQ.wdata[IC_EN];
                    end
                end
            endcase
        end

        // Trap entry: exception or interrupt, always into machine mode
        if (take_exc || take_irq) begin
            next_st.prior_irq_enable = st.mie;
            next_st.mie = 1'b0;
            next_st.prior_priv_mode = st.priv;
            next_st.priv = PRIV_M;
            next_st.epc = CORE_REQ.pc;
            next_st.cause_int = take_irq;
            next_st.code = take_irq ? {4'h0, arb_id} : CORE_REQ.exc_code;
            next_st.trap.pc_load = 1'b1;
            next_st.trap.irq = take_irq;
            // Controller modes ask for a 64-byte aligned base
            base = clic ? {st.tvec[31:6], 6'h00} : {st.tvec[31:2], 2'h0};
            next_st.trap.pc = base;
            if (take_irq) begin
                if (clic) begin
                    next_st.prior_irq_level = st.lvl;
                    next_st.lvl = arb_lvl;
                end
                case (st.tvec[1:0])
                    MODE_VECTORED: begin
                        next_st.trap.pc = base + {22'h0, arb_id, 2'h0};
                    end
                    MODE_CLIC_VEC: begin
                        // Core fetches the handler address from this slot
                        next_st.trap.pc = st.tvt + {22'h0, arb_id, 2'h0};
                        next_st.trap.vec_table = 1'b1;
                    end
                    default: next_st.trap.pc = base;
                endcase
            end
        end else if (mret_go) begin
            next_st.priv = st.prior_priv_mode;
            next_st.mie = st.prior_irq_enable;
            next_st.prior_irq_enable = 1'b1;
            next_st.prior_priv_mode = PRIV_U;
            if (clic) begin
                next_st.lvl = st.prior_irq_level;
            end
            next_st.trap.pc_load = 1'b1;
            next_st.trap.pc = st.epc;
        end
    end

    // State register; reset loads constants only
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st <= '0;
            st.priv <= PRIV_M;
            st.lvl <= LVL_BASE;
            st.tvec <= RST_TVEC;
            st.nlbits <= RST_NLBITS;
        end else begin
            st <= next_st;
        end
    end

    // Checks and scenario coverage
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_no_take_off: assert property (!st.mie |=> !TRAP_OUT.irq)
        else $error("interrupt taken with global enable clear");

    a_preempt_higher: assert property (
        (st.mie && arb_valid && clic && arb_lvl > st.lvl && !CORE_REQ.exc && !CORE_REQ.mret)
        |=> st.trap.pc_load && st.trap.irq && !st.mie)
        else $error("higher level interrupt did not preempt");

    a_entry_enable: assert property (
        take_irq |=> (!st.mie && st.prior_irq_enable == $past(st.mie) && st.cause_int))
        else $error("entry did not save and clear enable");

    a_entry_level: assert property (
        (take_irq && clic)
        |=> (st.lvl == $past(arb_lvl) && st.prior_irq_level == $past(st.lvl)))
        else $error("entry level save or load wrong");

    a_entry_priv: assert property (
        (take_irq || take_exc) |=> (st.prior_priv_mode == $past(st.priv) && st.priv == PRIV_M))
        else $error("entry privilege bookkeeping wrong");

    a_entry_pc: assert property (
        (take_irq || take_exc) |=> (st.epc == $past(CORE_REQ.pc) && TRAP_OUT.pc_load)
        ##1 (!TRAP_OUT.pc_load || $past(CORE_REQ.exc) || $past(CORE_REQ.mret)))
        else $error("entry pc save or redirect wrong");

    a_vec_plain: assert property (
        (take_irq && st.tvec[1:0] == MODE_VECTORED)
        |=> TRAP_OUT.pc == ({$past(st.tvec[31:2]), 2'h0} + {22'h0, $past(arb_id), 2'h0}))
        else $error("vectored target wrong");

    a_mret_state: assert property (
        mret_go |=> (st.priv == $past(st.prior_priv_mode)
                     && st.mie == $past(st.prior_irq_enable)))
        else $error("return did not restore privilege or enable");

    a_mret_level: assert property (
        (mret_go && clic) |=> st.lvl == $past(st.prior_irq_level))
        else $error("return did not restore level");

    a_mret_pc: assert property (
        mret_go |=> (TRAP_OUT.pc_load && TRAP_OUT.pc == $past(st.epc)))
        else $error("return pc wrong");

    a_enable_held: assert property (
        (!st.mie && !mret_go && !(REG_REQ.wr && REG_REQ.addr == OFF_STATUS)) |=> !st.mie)
        else $error("enable came back by itself");

    a_plain_arch: assert property (
        (take_irq && !clic) |-> (arb_id == ID_SW || arb_id == ID_TIMER || arb_id == ID_EXT))
        else $error("plain mode took a local interrupt");

    a_rd_data: assert property (
        (REG_REQ.rd && REG_REQ.addr == OFF_INTSTATUS)
        |=> REG_RDATA == {$past(st.lvl), 24'h00_0000})
        else $error("level status read wrong");

    c_clic_vec: cover property (take_irq && st.tvec[1:0] == MODE_CLIC_VEC);
    c_nested: cover property (take_irq && st.lvl != LVL_BASE);
    c_mret_back: cover property (take_irq ##[1:100] mret_go);
    c_exc_entry: cover property (take_exc && st.mie);
endmodule

// File: lit_pkg.sv
package lit_pkg;

    // Interrupt identity space: architectural ids plus 127 local lines
    localparam int          NUM_ID     = 144;
    localparam int          NUM_LOCAL  = 127;
    localparam logic [7:0]  ID_SW      = 8'h03;
    localparam logic [7:0]  ID_TIMER   = 8'h07;
    localparam logic [7:0]  ID_EXT     = 8'h0b;
    localparam int          ID_LOCAL0  = 16;

    // Privilege encodings
    localparam logic [1:0]  PRIV_U     = 2'h0;
    localparam logic [1:0]  PRIV_M     = 2'h3;

    // Trap vector mode encodings
    localparam logic [1:0]  MODE_DIRECT    = 2'h0;
    localparam logic [1:0]  MODE_VECTORED  = 2'h1;
    localparam logic [1:0]  MODE_CLIC_DIR  = 2'h2;
    localparam logic [1:0]  MODE_CLIC_VEC  = 2'h3;

    // Register byte offsets
    localparam logic [11:0] OFF_STATUS    = 12'h000;
    localparam logic [11:0] OFF_CAUSE     = 12'h004;
    localparam logic [11:0] OFF_TVEC      = 12'h008;
    localparam logic [11:0] OFF_EPC       = 12'h00c;
    localparam logic [11:0] OFF_TVT       = 12'h010;
    localparam logic [11:0] OFF_INTSTATUS = 12'h014;
    localparam logic [11:0] OFF_CFG       = 12'h018;
    localparam logic [11:0] OFF_IRQ_BASE  = 12'h400;

    // Field positions
    localparam int ST_MIE     = 3;
    localparam int ST_PEN     = 7;
    localparam int ST_PPM     = 11;
    localparam int CA_INT     = 31;
    localparam int CA_PPM     = 28;
    localparam int CA_PEN     = 27;
    localparam int CA_PLV     = 16;
    localparam int IS_LVL     = 24;
    localparam int IC_EN      = 8;
    localparam int IC_PEND    = 9;

    // Reset values and limits
    localparam logic [31:0] RST_TVEC    = 32'h0000_0000;
    localparam logic [3:0]  RST_NLBITS  = 4'h0;
    localparam logic [3:0]  MAX_NLBITS  = 4'h4;
    localparam logic [7:0]  LVL_BASE    = 8'h00;

    // Register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } lit_reg_req_t;

    // Core events toward the trap logic
    typedef struct packed {
        logic [31:0] pc;
        logic        exc;
        logic [11:0] exc_code;
        logic        mret;
    } lit_core_req_t;

    // Redirect handed back to the core
    typedef struct packed {
        logic        pc_load;
        logic [31:0] pc;
        logic        vec_table;
        logic        irq;
    } lit_trap_t;

    // Whole state of the trap controller
    typedef struct packed {
        logic [NUM_ID-1:0]       sync1;
        logic [NUM_ID-1:0]       sync2;
        logic                    mie;
        logic                    prior_irq_enable;
        logic [1:0]              prior_priv_mode;
        logic [1:0]              priv;
        logic [7:0]              lvl;
        logic [7:0]              prior_irq_level;
        logic                    cause_int;
        logic [11:0]             code;
        logic [31:0]             tvec;
        logic [31:0]             epc;
        logic [31:0]             tvt;
        logic [3:0]              nlbits;
        logic [NUM_ID-1:0]       ien;
        logic [NUM_ID-1:0][7:0]  icfg;
        logic [31:0]             rdata;
        lit_trap_t               trap;
    } lit_state_t;

    // Level field of a config byte, unused low bits read as ones
    function automatic logic [7:0] lit_level(input logic [7:0] cfg, input logic [3:0] nlbits);
        logic [7:0] m;
        m = ~(8'hff >> nlbits);
        return (cfg & m) | ~m;
    endfunction

    // Per-interrupt window decode: hit flag and index
    function automatic logic [8:0] lit_irq_sel(input logic [11:0] addr);
        logic [11:0] rel;
        rel = addr - OFF_IRQ_BASE;
        if (addr >= OFF_IRQ_BASE && rel[1:0] == 2'h0 && rel[11:2] < 10'(NUM_ID)) begin
            return {1'b1, rel[9:2]};
        end
        return 9'h000;
    endfunction

endpackage

// File: lit_arbiter.sv
`timescale 1ns/1ps
module lit_arbiter import lit_pkg::*; (
    input  wire logic [NUM_ID-1:0]      pend,
    input  wire logic [NUM_ID-1:0]      en,
    input  wire logic [NUM_ID-1:0][7:0] cfg,
    input  wire logic                   clic,
    output logic                        valid,
    output logic [7:0]                  id,
    output logic [7:0]                  win_cfg
);
    // Ids that exist in each family of vector modes
    logic [NUM_ID-1:0] arch_mask;
    logic [NUM_ID-1:0] impl_mask;

    always_comb begin
        arch_mask = '0;
        arch_mask[ID_SW] = 1'b1;
        arch_mask[ID_TIMER] = 1'b1;
        arch_mask[ID_EXT] = 1'b1;
        impl_mask = arch_mask;
        for (int i = ID_LOCAL0; i < ID_LOCAL0 + NUM_LOCAL; i++) begin
            impl_mask[i] = 1'b1;
        end
    end

    // Highest config byte wins, ties go to the larger id
    // A flat scan: deep but combinational, keeps latency at zero cycles
    always_comb begin
        logic [NUM_ID-1:0] elig;
        elig = pend & en & (clic ? impl_mask : arch_mask);
        valid = 1'b0;
        id = 8'h00;
        win_cfg = 8'h00;
        for (int i = 0; i < NUM_ID; i++) begin
            // Ascending scan with >= makes the later id win a tie
            if (elig[i] && (!valid || cfg[i] >= win_cfg)) begin
                valid = 1'b1;
                id = 8'(i);
                win_cfg = cfg[i];
            end
        end
    end
endmodule

// File: lit_irq_src.sv
`timescale 1ns/1ps
// Far-side sources: level lines that follow a request after a lag
module lit_irq_src import lit_pkg::*; (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic [NUM_ID-1:0]    want,
    input  wire logic [3:0]           lag,
    output logic      [NUM_LOCAL-1:0] irq_local,
    output logic                      irq_sw,
    output logic                      irq_timer,
    output logic                      irq_ext
);
    logic [NUM_ID-1:0] shown;    // Levels now on the wires
    logic [3:0]        wait_cnt; // Cycles a change has waited

    // Lag lets one model act as a prompt or a slow source
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shown    <= '0;
            wait_cnt <= 4'h0;
        end else if (want == shown) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= lag) begin
            shown    <= want;
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end

    // Local lines start at id 16, the rest keep their codes
    assign irq_local = shown[ID_LOCAL0 +: NUM_LOCAL];
    assign irq_sw    = shown[ID_SW];
    assign irq_timer = shown[ID_TIMER];
    assign irq_ext   = shown[ID_EXT];
endmodule

// File: local_irq_trap_control_bench.sv
`timescale 1ns/1ps
module local_irq_trap_control_bench import lit_pkg::*; ;
    logic                 clk      = 1'b0; // Core clock
    logic                 reset_n  = 1'b0; // Core reset
    lit_reg_req_t         reg_req  = '0;   // Register port
    logic [31:0]          reg_rdata;
    lit_core_req_t        core_req = '0;   // Core events
    lit_trap_t            trap_out;
    logic [NUM_ID-1:0]    want     = '0;   // Requested source levels
    logic [3:0]           lag      = 4'h0;
    logic [NUM_LOCAL-1:0] irq_local;
    logic                 irq_sw;
    logic                 irq_timer;
    logic                 irq_ext;
    int                   bad_count = 0;
    int                   checked   = 0;
    int                   seed      = 29566;
    // Reference model of the hart state
    int                   m_en[NUM_ID];
    int                   m_cfg[NUM_ID];
    int                   m_mie, m_pen, m_ppm, m_priv, m_lvl, m_plv, m_int, m_code;
    int                   m_mode, m_nlbits;
    logic [31:0]          m_epc, m_base, m_tvt, rd_val;

    always #25 clk = ~clk;

    lit_irq_src u_src (
        .clk       (clk),
        .reset_n   (reset_n),
        .want      (want),
        .lag       (lag),
        .irq_local (irq_local),
        .irq_sw    (irq_sw),
        .irq_timer (irq_timer),
        .irq_ext   (irq_ext)
    );

    lit_trap_ctrl u_dut (
        .CLK       (clk),
        .RESET_N   (reset_n),
        .REG_REQ   (reg_req),
        .REG_RDATA (reg_rdata),
        .CORE_REQ  (core_req),
        .TRAP_OUT  (trap_out),
        .IRQ_LOCAL (irq_local),
        .IRQ_SW    (irq_sw),
        .IRQ_TIMER (irq_timer),
        .IRQ_EXT   (irq_ext)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One-cycle strobes, launched right after an edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        @(negedge clk);
        rd_val = reg_rdata;
        chk(rd_val, exp, what);
    endtask

    function automatic logic [NUM_ID-1:0] ids(input int a, input int b, input int c, input int d);
        logic [NUM_ID-1:0] v;
        v = '0;
        v[a] = 1'b1;
        v[b] = 1'b1;
        v[c] = 1'b1;
        v[d] = 1'b1;
        return v;
    endfunction

    function automatic logic [31:0] stat_w();
        return {19'h0, 2'(m_ppm), 3'h0, 1'(m_pen), 3'h0, 1'(m_mie), 3'h0};
    endfunction

    function automatic logic [31:0] cause_w();
        return {1'(m_int), 1'b0, 2'(m_ppm), 1'(m_pen), 3'h0, 8'(m_plv), 4'h0, 12'(m_code)};
    endfunction

    // Unused low config bits read as ones
    function automatic int lvl_of(input int cfg);
        int m;
        m = (32'hff << (8 - m_nlbits)) & 32'hff;
        return (cfg & m) | (~m & 32'hff);
    endfunction

    // Winner: highest config byte, ties to the largest id
    function automatic int pick();
        int w;
        w = -1;
        for (int i = 0; i < NUM_ID; i++) begin
            if (want[i] && m_en[i] != 0 && (m_mode >= 2 || i == 3 || i == 7 || i == 11)) begin
                if (w < 0 || m_cfg[i] >= m_cfg[w]) w = i;
            end
        end
        return w;
    endfunction

    function automatic logic [31:0] target(input int id);
        case (m_mode)
            1: return m_base + 32'(4 * id);
            3: return m_tvt + 32'(4 * id);
            default: return m_base;
        endcase
    endfunction

    task automatic model_entry(input int id, input int is_irq, input int code);
        m_pen  = m_mie;
        m_mie  = 0;
        m_ppm  = m_priv;
        m_priv = 3;
        m_int  = is_irq;
        m_code = code;
        m_epc  = core_req.pc & 32'hffff_fffe;
        if (is_irq != 0 && m_mode >= 2) begin
            m_plv  = m_lvl;
            m_lvl  = lvl_of(m_cfg[id]);
        end
    endtask

    // Bounded wait for a redirect, then the pulse must end
    task automatic expect_jump(input logic [31:0] pc, input logic irq, input logic vt);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (trap_out.pc_load !== 1'b1 && n < 30);
        chk(32'({trap_out.pc_load, trap_out.irq, trap_out.vec_table}),
            32'({1'b1, irq, vt}), "kind");
        chk(trap_out.pc, pc, "target pc");
        @(negedge clk);
        chk(32'(trap_out.pc_load), 32'h0, "pulse length");
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clk);
            chk(32'(trap_out.pc_load), 32'h0, "no redirect");
        end
    endtask

    task automatic raise(input logic [NUM_ID-1:0] src, input logic [3:0] lg);
        @(posedge clk);
        lag <= lg;
        want <= src;
        core_req.pc <= 32'($random(seed)) & 32'hffff_fffc;
    endtask

    task automatic enter();
        int id;
        @(negedge clk);
        id = pick();
        expect_jump(target(id), 1'b1, 1'(m_mode == 3));
        model_entry(id, 1, id);
        rchk(OFF_STATUS, stat_w(), "status");
        rchk(OFF_CAUSE, cause_w(), "cause");
        rchk(OFF_EPC, m_epc, "saved pc");
        rchk(OFF_INTSTATUS, {8'(m_lvl), 24'h0}, "level");
        rchk(OFF_IRQ_BASE + 12'(4 * id), 32'h300 | 32'(m_cfg[id]), "pending");
    endtask

    // Drop all sources, let the synchronisers clear, then return
    task automatic leave();
        @(posedge clk);
        want <= '0;
        lag <= 4'h0;
        repeat (4) @(posedge clk);
        core_req.mret <= 1'b1;
        @(posedge clk);
        core_req.mret <= 1'b0;
        expect_jump(m_epc, 1'b0, 1'b0);
        m_priv = m_ppm;
        m_ppm  = 0;
        m_mie  = m_pen;
        m_pen  = 1;
        if (m_mode >= 2) m_lvl = m_plv;
        rchk(OFF_STATUS, stat_w(), "status after return");
        rchk(OFF_INTSTATUS, {8'(m_lvl), 24'h0}, "level after return");
    endtask

    task automatic exc_round();
        logic [11:0] code;
        code = 12'($random(seed));
        @(posedge clk);
        core_req.exc <= 1'b1;
        core_req.exc_code <= code;
        @(posedge clk);
        core_req.exc <= 1'b0;
        expect_jump(m_base, 1'b0, 1'b0);
        model_entry(0, 0, int'(code));
        rchk(OFF_STATUS, stat_w(), "status after exception");
        rchk(OFF_CAUSE, cause_w(), "cause after exception");
    endtask

    task automatic cfg_irq(input int id, input int cfg);
        m_en[id] = 1;
        m_cfg[id] = cfg;
        wr(OFF_IRQ_BASE + 12'(4 * id), 32'h100 | 32'(cfg));
        rchk(OFF_IRQ_BASE + 12'(4 * id), 32'h100 | 32'(cfg), "irq config");
    endtask

    task automatic set_mode(input int md);
        m_mode = md;
        wr(OFF_TVEC, m_base | 32'(md));
        rchk(OFF_TVEC, m_base | 32'(md), "vector mode");
    endtask

    // Watchdog sized well above the few hundred cycles used
    initial begin
        #1000000;
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        m_base = 32'h0000_1000;
        m_tvt  = 32'h0000_2000;
        m_priv = 3;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // Reset state and refused accesses
        rchk(OFF_TVEC, RST_TVEC, "tvec reset");
        rchk(OFF_INTSTATUS, 32'h0, "level at reset");
        wr(OFF_INTSTATUS, 32'hff00_0000);
        rchk(OFF_INTSTATUS, 32'h0, "level read only");
        wr(12'h020, 32'hffff_ffff);
        rchk(12'h020, 32'h0, "unmapped");
        wr(OFF_TVT, m_tvt);
        cfg_irq(3, 1);
        cfg_irq(7, 2);
        cfg_irq(11, 3);
        cfg_irq(20, 8'hf0);
        // Global enable gates every interrupt, handler stays masked
        set_mode(1);
        raise(ids(7, 20, 20, 20), 4'h3);
        quiet(12);
        m_mie = 1;
        wr(OFF_STATUS, stat_w());
        enter();
        quiet(8);
        leave();
        // Plain direct, plain vectored and controller direct modes, prompt and slow sources
        for (int md = 0; md < 3; md++) begin
            set_mode(md);
            raise(ids(11, 20, 11, 11), 4'(md));
            enter();
            leave();
        end
        // Exceptions and a return into user mode
        set_mode(0);
        exc_round();
        leave();
        leave();
        exc_round();
        leave();
        // Controller vectored mode with four level bits
        wr(OFF_CFG, 32'h1e);
        m_nlbits = 4;
        rchk(OFF_CFG, 32'h8, "level bits clamp");
        cfg_irq(40, 8'h37);
        cfg_irq(20, 8'h37);
        cfg_irq(60, 8'h35);
        cfg_irq(80, 8'h55);
        set_mode(3);
        raise(ids(20, 40, 60, 60), 4'h5);
        enter();
        m_mie = 1;
        wr(OFF_STATUS, stat_w());
        quiet(10);
        raise(ids(20, 40, 60, 80), 4'h0);
        enter();
        leave();
        report_and_stop();
    end
endmodule
